// >>> pkg/r2mf_cfg.svh
// Bit positions, reset values and tone sets of the signaling controller
`ifndef R2MF_CFG_SVH
`define R2MF_CFG_SVH

// =====================================
// Command byte fields
`define R2MF_B_TONE     7
`define R2MF_B_CHN      6
`define R2MF_B_CLKSRC   5
`define R2MF_B_CODING   4
`define R2MF_B_EN       3
`define R2MF_B_EOT      2
`define R2MF_B_AUTO     1
`define R2MF_B_DIR      0
`define R2MF_CFG1_SEL   2'b00
`define R2MF_CFG2_SEL   2'b01

// =====================================
// Reset values
`define R2MF_RST_EOT    1'b1
`define R2MF_RST_DIR    1'b1
`define R2MF_RST_EN     1'b0
`define R2MF_RST_AUTO   1'b0
`define R2MF_RST_CODING 1'b0
`define R2MF_RST_CLKSRC 1'b1
`define R2MF_RST_LATCH  8'h00

// =====================================
// Tone sets in Hz
`define R2MF_FWD_LO_HZ  1380
`define R2MF_FWD_HI_HZ  1980
`define R2MF_BWD_LO_HZ  540
`define R2MF_BWD_HI_HZ  1140
`define R2MF_STEP_HZ    120

`endif

// >>> pkg/r2mf_pkg.sv
// Types and tone code functions of the signaling controller
package r2mf_pkg;

   typedef enum logic [1:0] {
      R2MF_ST_IDLE = 2'b01,
      R2MF_ST_SIG  = 2'b10
   } r2mf_state_e;

   typedef struct packed {
      r2mf_state_e state;
      logic        pend;
      logic [5:0]  pend_flags;
      logic [5:0]  tx_flags;
      logic        tx_on;
      logic        rise;
      logic        fall;
   } r2mf_chan_s;

   typedef struct packed {
      logic            wr_s1;
      logic            wr_s2;
      logic            wr_p;
      logic            rd_s1;
      logic            rd_s2;
      logic [7:0]      dat_s1;
      logic [7:0]      dat_s2;
      logic [7:0]      cmd;
      logic            cmd_vld;
      logic            rx_empty;
      logic            full_n;
      logic            oe;
      logic [7:0]      latch;
      logic [7:0]      out;
      logic            clk_ext;
      logic            binary;
      logic [1:0]      en;
      logic [1:0]      eot;
      logic [1:0]      auto_on;
      logic [1:0]      fwd;
      logic [1:0]      pend;
      logic [1:0][7:0] evt;
   } r2mf_host_s;

   // Code 0 is tone off; each other code is one pair, bit 0 lowest index
   function automatic logic [5:0] r2mf_code2flags(input logic [3:0] code);
      case (code)
         4'h1:    r2mf_code2flags = 6'h03;
         4'h2:    r2mf_code2flags = 6'h05;
         4'h3:    r2mf_code2flags = 6'h06;
         4'h4:    r2mf_code2flags = 6'h09;
         4'h5:    r2mf_code2flags = 6'h0a;
         4'h6:    r2mf_code2flags = 6'h0c;
         4'h7:    r2mf_code2flags = 6'h11;
         4'h8:    r2mf_code2flags = 6'h12;
         4'h9:    r2mf_code2flags = 6'h14;
         4'ha:    r2mf_code2flags = 6'h18;
         4'hb:    r2mf_code2flags = 6'h21;
         4'hc:    r2mf_code2flags = 6'h22;
         4'hd:    r2mf_code2flags = 6'h24;
         4'he:    r2mf_code2flags = 6'h28;
         4'hf:    r2mf_code2flags = 6'h30;
         default: r2mf_code2flags = 6'h00;
      endcase
   endfunction

   function automatic logic [3:0] r2mf_flags2code(input logic [5:0] flags);
      logic [3:0] i;
      r2mf_flags2code = 4'h0;
      for (int k = 1; k < 16; k++) begin
         i = 4'(k);
         if (r2mf_code2flags(i) == flags) begin
            r2mf_flags2code = i;
         end
      end
   endfunction

endpackage

// >>> verilog/r2mf_chan.sv
// Compelled signaling state machine of one channel
`timescale 1ns/1ps

module r2mf_chan (
   input  wire logic       sys_clk,
   input  wire logic       reset_n,
   input  wire logic       en,
   input  wire logic       auto_on,
   input  wire logic       fwd,
   input  wire logic       cmd_stb,
   input  wire logic [5:0] cmd_flags,
   input  wire logic       det_on,
   output logic            tx_on,
   output logic [5:0]      tx_flags,
   output logic            rise,
   output logic            fall
);

   r2mf_pkg::r2mf_chan_s q;
   r2mf_pkg::r2mf_chan_s d;
   logic                 go_sig;
   logic                 go_idle;
   logic                 act;

   always_comb begin
      d       = q;
      d.rise  = 1'b0;
      d.fall  = 1'b0;
      go_sig  = 1'b0;
      go_idle = 1'b0;
      // Disabled channel ignores its detector and holds its state
      case (q.state)
         r2mf_pkg::R2MF_ST_IDLE: begin
            if (en && det_on) begin
               go_sig  = 1'b1;
               d.state = r2mf_pkg::R2MF_ST_SIG;
               d.rise  = 1'b1;
            end
         end
         r2mf_pkg::R2MF_ST_SIG: begin
            if (en && !det_on) begin
               go_idle = 1'b1;
               d.state = r2mf_pkg::R2MF_ST_IDLE;
               d.fall  = 1'b1;
            end
         end
         default: d.state = r2mf_pkg::R2MF_ST_IDLE;
      endcase
      // Transmit-permitting state: idle going forward, signal going backward
      act = fwd ? (d.state == r2mf_pkg::R2MF_ST_IDLE) : (d.state == r2mf_pkg::R2MF_ST_SIG);
      if (!auto_on) begin
         d.pend = 1'b0;
         if (cmd_stb) begin
            d.tx_flags = cmd_flags;
         end
      end else begin
         if (go_sig || go_idle) begin
            if (!act) begin
               d.tx_flags = 6'h00;
            end else if (q.pend) begin
               d.tx_flags = q.pend_flags;
               d.pend     = 1'b0;
            end
         end
         if (cmd_stb) begin
            if (act) begin
               d.tx_flags = cmd_flags;
               d.pend     = 1'b0;
            end else begin
               d.pend       = 1'b1;
               d.pend_flags = cmd_flags;
            end
         end
      end
      d.tx_on = |d.tx_flags;
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         q <= '{state: r2mf_pkg::R2MF_ST_IDLE, default: '0};
      end else begin
         q <= d;
      end
   end

   assign tx_on    = q.tx_on;
   assign tx_flags = q.tx_flags;
   assign rise     = q.rise;
   assign fall     = q.fall;

   property p_fwd_cmd_now;
      @(posedge sys_clk) disable iff (!reset_n)
      auto_on && fwd && q.state == r2mf_pkg::R2MF_ST_IDLE && !(en && det_on) && cmd_stb
      |=> tx_flags == $past(cmd_flags);
   endproperty
   a_fwd_cmd_now: assert property (p_fwd_cmd_now) else $error("forward command not started at once");

   property p_fwd_sig_off;
      @(posedge sys_clk) disable iff (!reset_n)
      auto_on && fwd && go_sig |=> !tx_on ##1 (!tx_on || $past(!fwd || !auto_on || go_idle || cmd_stb));
   endproperty
   a_fwd_sig_off: assert property (p_fwd_sig_off) else $error("transmitter on after backward signal");

   property p_pend_run;
      @(posedge sys_clk) disable iff (!reset_n)
      auto_on && q.pend && (fwd ? go_idle : go_sig) && !cmd_stb |=> tx_flags == $past(q.pend_flags) && !q.pend;
   endproperty
   a_pend_run: assert property (p_pend_run) else $error("pending command not run on entry");

   property p_bwd_idle_off;
      @(posedge sys_clk) disable iff (!reset_n)
      auto_on && !fwd && go_idle |=> !tx_on;
   endproperty
   a_bwd_idle_off: assert property (p_bwd_idle_off) else $error("backward idle entry left tone on");

   property p_bwd_cmd_now;
      @(posedge sys_clk) disable iff (!reset_n)
      auto_on && !fwd && q.state == r2mf_pkg::R2MF_ST_SIG && !(en && !det_on) && cmd_stb
      |=> tx_flags == $past(cmd_flags);
   endproperty
   a_bwd_cmd_now: assert property (p_bwd_cmd_now) else $error("backward command not started at once");

   property p_bwd_hold;
      @(posedge sys_clk) disable iff (!reset_n)
      auto_on && !fwd && q.state == r2mf_pkg::R2MF_ST_IDLE && !(en && det_on) && cmd_stb
      |=> q.pend && $stable(tx_flags);
   endproperty
   a_bwd_hold: assert property (p_bwd_hold) else $error("backward idle command not held");

   property p_detect;
      @(posedge sys_clk) disable iff (!reset_n)
      en && det_on && q.state == r2mf_pkg::R2MF_ST_IDLE |=> rise ##1 !rise;
   endproperty
   a_detect: assert property (p_detect) else $error("detection did not enter signal state");

   property p_manual;
      @(posedge sys_clk) disable iff (!reset_n)
      !auto_on && cmd_stb |=> tx_flags == $past(cmd_flags) && tx_on == ($past(cmd_flags) != 6'h00);
   endproperty
   a_manual: assert property (p_manual) else $error("manual command not applied");

endmodule // r2mf_chan

// >>> verilog/r2mf_ctrl.sv
// Host latch port, configuration and tone reporting of the signaling controller
// How it works
// - Forward idle state starts commanded tone immediately
// - Forward signal state forces transmitter off
// - Forward signal-state command pends until idle
// - Backward idle state keeps transmitter off
// - Backward signal state starts commanded tone immediately
// - Backward idle entry stops; pending runs later
// - Detection enters signal state, reports tone
// - Loss returns idle; end code if enabled
// - Forward sends high set, hears low
// - Backward sends low set, hears high
// - Reset defaults: report on, forward, disabled
// - Latch shows zero byte after reset
// - Tone command: bit7, channel, flags/code
// - Return byte: bit7 clear, channel, coding
// - Tone report pulls full flag low
// - Write strobe raises empty; capture; clear
// - Read strobe raises full, drives data
// - Two config bytes set channel options
// - Manual mode: commands alone switch tone
// - Disabled channel ignores detector and commands
`timescale 1ns/1ps
`include "r2mf_cfg.svh"

module r2mf_ctrl #(
   parameter int NCHAN = 2
) (
   input  wire logic               sys_clk,
   input  wire logic               reset_n,
   input  wire logic               wr_n,
   input  wire logic               rd_n,
   input  wire logic [7:0]         host_data_lines_in,
   input  wire logic [NCHAN-1:0]   det_on,
   input  wire logic [NCHAN*6-1:0] det_flags,
   output logic [7:0]              host_data_lines_out,
   output logic                    host_data_lines_oe,
   output logic                    tx_latch_full_n,
   output logic                    rx_latch_empty,
   output logic                    codec_clock_source_sel,
   output logic                    tone_coding_sel,
   output logic [NCHAN-1:0]        channel_on,
   output logic [NCHAN-1:0]        end_of_tone_report,
   output logic [NCHAN-1:0]        auto_handshake_sel,
   output logic [NCHAN-1:0]        direction_sel,
   output logic [NCHAN-1:0]        tx_on,
   output logic [NCHAN*6-1:0]      tx_flags
);

   // =====================================
   // Parameter check
   if (NCHAN < 1 || NCHAN > 2) begin : g_bad_nchan
      $error("NCHAN must be 1 or 2");
   end

   // =====================================
   // State
   r2mf_pkg::r2mf_host_s q;
   r2mf_pkg::r2mf_host_s d;
   logic [1:0]           tone_stb;
   logic [5:0]           cmd_flags;
   logic                 cmd_ok;
   logic [1:0]           ch_rise;
   logic [1:0]           ch_fall;
   logic [1:0][5:0]      det_f;
   logic [1:0]           det_in;

   localparam r2mf_pkg::r2mf_host_s RST = '{
      wr_s1:    1'b1,
      wr_s2:    1'b1,
      wr_p:     1'b1,
      rd_s1:    1'b1,
      rd_s2:    1'b1,
      dat_s1:   8'h00,
      dat_s2:   8'h00,
      cmd:      8'h00,
      cmd_vld:  1'b0,
      rx_empty: 1'b0,
      full_n:   1'b0,
      oe:       1'b0,
      latch:    `R2MF_RST_LATCH,
      out:      8'h00,
      clk_ext:  `R2MF_RST_CLKSRC,
      binary:   `R2MF_RST_CODING,
      en:       {2{`R2MF_RST_EN}},
      eot:      {2{`R2MF_RST_EOT}},
      auto_on:  {2{`R2MF_RST_AUTO}},
      fwd:      {2{`R2MF_RST_DIR}},
      pend:     2'b00,
      evt:      16'h0000
   };

   // Return byte payload in the configured coding
   function automatic logic [5:0] ret_payload(input logic bin, input logic [5:0] f);
      ret_payload = bin ? {2'b00, r2mf_pkg::r2mf_flags2code(f)} : f;
   endfunction

   // =====================================
   // Detector inputs widened to two channels
   always_comb begin
      det_in = 2'b00;
      det_f  = '0;
      for (int c = 0; c < NCHAN; c++) begin
         det_in[c] = det_on[c];
         det_f[c]  = det_flags[c*6 +: 6];
      end
   end

   // =====================================
   // Tone command decode
   always_comb begin
      cmd_ok    = !q.binary || (q.cmd[5:4] == 2'b00);
      cmd_flags = q.binary ? r2mf_pkg::r2mf_code2flags(q.cmd[3:0]) : q.cmd[5:0];
      tone_stb  = 2'b00;
      for (int c = 0; c < 2; c++) begin
         if (q.cmd_vld && q.cmd[`R2MF_B_TONE] && cmd_ok && (q.cmd[`R2MF_B_CHN] == c[0])
             && q.en[c] && (c < NCHAN)) begin
            tone_stb[c] = 1'b1;
         end
      end
   end

   // =====================================
   // Next state
   always_comb begin
      d = q;
      // Strobes and data pass two flip-flops before use
      d.wr_s1   = wr_n;
      d.wr_s2   = q.wr_s1;
      d.wr_p    = q.wr_s2;
      d.rd_s1   = rd_n;
      d.rd_s2   = q.rd_s1;
      d.dat_s1  = host_data_lines_in;
      d.dat_s2  = q.dat_s1;
      d.cmd_vld = 1'b0;

      // Host write
      if (q.wr_s2 && !q.wr_p) begin
         d.cmd     = q.dat_s2;
         d.cmd_vld = 1'b1;
      end
      if (q.cmd_vld) begin
         d.rx_empty = 1'b0;
         if (!q.cmd[`R2MF_B_TONE]) begin
            if (q.cmd[7:6] == `R2MF_CFG1_SEL) begin
               d.clk_ext    = q.cmd[`R2MF_B_CLKSRC];
               d.binary     = q.cmd[`R2MF_B_CODING];
               d.en[0]      = q.cmd[`R2MF_B_EN];
               d.eot[0]     = q.cmd[`R2MF_B_EOT];
               d.auto_on[0] = q.cmd[`R2MF_B_AUTO];
               d.fwd[0]     = q.cmd[`R2MF_B_DIR];
            end else if (NCHAN > 1) begin
               d.en[1]      = q.cmd[`R2MF_B_EN];
               d.eot[1]     = q.cmd[`R2MF_B_EOT];
               d.auto_on[1] = q.cmd[`R2MF_B_AUTO];
               d.fwd[1]     = q.cmd[`R2MF_B_DIR];
            end
         end
      end

      // New strobe after the consume clear, so a set wins
      if (!q.wr_s2 && q.wr_p) begin
         d.rx_empty = 1'b1;
      end

      // Host read: data stands while the strobe is low
      if (!q.rd_s2) begin
         d.oe     = 1'b1;
         d.out    = q.latch;
         d.full_n = 1'b1;
      end else begin
         d.oe = 1'b0;
      end

      // Latch refill, lowest channel first, never under a read
      if (q.full_n && q.rd_s2) begin
         if (q.pend[0]) begin
            d.latch   = q.evt[0];
            d.full_n  = 1'b0;
            d.pend[0] = 1'b0;
         end else if (q.pend[1]) begin
            d.latch   = q.evt[1];
            d.full_n  = 1'b0;
            d.pend[1] = 1'b0;
         end
      end

      // New events set after the refill clear, so a set wins
      for (int c = 0; c < 2; c++) begin
         if (ch_rise[c]) begin
            d.pend[c] = 1'b1;
            d.evt[c]  = {1'b0, c[0], ret_payload(q.binary, det_f[c])};
         end else if (ch_fall[c] && q.eot[c]) begin
            d.pend[c] = 1'b1;
            d.evt[c]  = {1'b0, c[0], 6'h00};
         end
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         q <= RST;
      end else begin
         q <= d;
      end
   end

   // =====================================
   // Channel machines
   logic [1:0]      c_tx_on;
   logic [1:0][5:0] c_tx_flags;

   for (genvar g = 0; g < 2; g++) begin : g_chan
      if (g < NCHAN) begin : g_on
         r2mf_chan u_chan (
            .sys_clk   (sys_clk),
            .reset_n   (reset_n),
            .en        (q.en[g]),
            .auto_on   (q.auto_on[g]),
            .fwd       (q.fwd[g]),
            .cmd_stb   (tone_stb[g]),
            .cmd_flags (cmd_flags),
            .det_on    (det_in[g]),
            .tx_on     (c_tx_on[g]),
            .tx_flags  (c_tx_flags[g]),
            .rise      (ch_rise[g]),
            .fall      (ch_fall[g])
         );
      end else begin : g_off
         assign c_tx_on[g]    = 1'b0;
         assign c_tx_flags[g] = 6'h00;
         assign ch_rise[g]    = 1'b0;
         assign ch_fall[g]    = 1'b0;
      end
   end

   // =====================================
   // Outputs
   assign host_data_lines_out    = q.out;
   assign host_data_lines_oe     = q.oe;
   assign tx_latch_full_n        = q.full_n;
   assign rx_latch_empty         = q.rx_empty;
   assign codec_clock_source_sel = q.clk_ext;
   assign tone_coding_sel        = q.binary;
   assign channel_on             = q.en[NCHAN-1:0];
   assign end_of_tone_report     = q.eot[NCHAN-1:0];
   assign auto_handshake_sel     = q.auto_on[NCHAN-1:0];
   // High selects forward send set and backward receive set
   assign direction_sel          = q.fwd[NCHAN-1:0];

   always_comb begin
      tx_on    = '0;
      tx_flags = '0;
      for (int c = 0; c < NCHAN; c++) begin
         tx_on[c]          = c_tx_on[c];
         tx_flags[c*6 +: 6] = c_tx_flags[c];
      end
   end

   // =====================================
   // Checks
   property p_wr_low;
      @(posedge sys_clk) disable iff (!reset_n)
      !q.wr_s2 && q.wr_p |=> rx_latch_empty;
   endproperty
   a_wr_low: assert property (p_wr_low) else $error("empty flag not raised on write");

   property p_wr_done;
      @(posedge sys_clk) disable iff (!reset_n)
      q.wr_s2 && !q.wr_p |=> q.cmd == $past(q.dat_s2) ##1 !rx_latch_empty;
   endproperty
   a_wr_done: assert property (p_wr_done) else $error("written byte not taken or flag not cleared");

   property p_read;
      @(posedge sys_clk) disable iff (!reset_n)
      !q.rd_s2 |=> host_data_lines_oe && tx_latch_full_n && host_data_lines_out == $past(q.latch);
   endproperty
   a_read: assert property (p_read) else $error("read strobe not answered");

   property p_report;
      @(posedge sys_clk) disable iff (!reset_n)
      $fell(tx_latch_full_n) |-> !q.latch[7] && q.latch == $past(q.pend[0] ? q.evt[0] : q.evt[1]);
   endproperty
   a_report: assert property (p_report) else $error("report byte malformed");

   property p_cfg1;
      @(posedge sys_clk) disable iff (!reset_n)
      q.cmd_vld && q.cmd[7:6] == `R2MF_CFG1_SEL
      |=> tone_coding_sel == $past(q.cmd[4]) && channel_on[0] == $past(q.cmd[3]);
   endproperty
   a_cfg1: assert property (p_cfg1) else $error("configuration byte not applied");

   property p_disabled;
      @(posedge sys_clk) disable iff (!reset_n)
      q.cmd_vld && q.cmd[7] && !q.en[q.cmd[6]] |-> tone_stb == 2'b00;
   endproperty
   a_disabled: assert property (p_disabled) else $error("disabled channel took a command");

   property p_no_eot;
      @(posedge sys_clk) disable iff (!reset_n)
      ch_fall[0] && !q.eot[0] && !q.pend[0] |=> !q.pend[0];
   endproperty
   a_no_eot: assert property (p_no_eot) else $error("end code sent with reporting off");

endmodule // r2mf_ctrl

// >>> tb/r2mf_host.sv
// Host processor model driving the latch strobes
`timescale 1ns/1ps

module r2mf_host (
   input  wire logic       sys_clk,
   output logic            wr_n,
   output logic            rd_n,
   output logic [7:0]      dout,
   input  wire logic [7:0] din,
   input  wire logic       oe,
   input  wire logic       full_n,
   input  wire logic       empty
);
   initial begin
      wr_n = 1'b1;
      rd_n = 1'b1;
      dout = 8'h5a;
   end

   // =====================================
   // Strobe cycles
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic write_byte(input logic [7:0] b, output logic ok);
      int k;
      k = 0;
      tick(1);
      wr_n = 1'b0;
      dout = b;
      tick(4);
      ok = (empty === 1'b1);
      wr_n = 1'b1;
      tick(4);
      while (empty !== 1'b0 && k < 50) begin
         tick(1);
         k++;
      end
      ok = ok & (empty === 1'b0);
      // Released lines show the inverse, not the old byte
      dout = ~b;
   endtask

   task automatic read_byte(output logic [7:0] b, output logic ok);
      int k;
      k = 0;
      b = 8'h00;
      while (full_n !== 1'b0 && k < 50) begin
         tick(1);
         k++;
      end
      ok = (full_n === 1'b0);
      if (ok) begin
         rd_n = 1'b0;
         tick(4);
         ok = (oe === 1'b1) && (full_n === 1'b1);
         b = din;
         rd_n = 1'b1;
         tick(5);
      end
   endtask
endmodule // r2mf_host

// >>> tb/r2mf_ctrl_tb.sv
// Self-checking bench of the signaling controller
`timescale 1ns/1ps

module r2mf_ctrl_tb;
   logic        sys_clk, reset_n, wr_n, rd_n, oe, full_n, empty, clk_src, coding;
   logic [7:0]  hd_in, hd_out;
   logic [1:0]  det_on, ch_on, eot, auto_sel, dir, tx_on;
   logic [11:0] det_flags, tx_flags;
   int          miscompares, cmp_count, cycles;
   logic [5:0]  pairs [16] = '{6'h00, 6'h03, 6'h05, 6'h06, 6'h09, 6'h0a, 6'h0c, 6'h11,
                               6'h12, 6'h14, 6'h18, 6'h21, 6'h22, 6'h24, 6'h28, 6'h30};

   r2mf_ctrl r2mf_ctrl_i (
      .sys_clk(sys_clk), .reset_n(reset_n), .wr_n(wr_n), .rd_n(rd_n),
      .host_data_lines_in(hd_in), .det_on(det_on), .det_flags(det_flags),
      .host_data_lines_out(hd_out), .host_data_lines_oe(oe), .tx_latch_full_n(full_n),
      .rx_latch_empty(empty), .codec_clock_source_sel(clk_src), .tone_coding_sel(coding),
      .channel_on(ch_on), .end_of_tone_report(eot), .auto_handshake_sel(auto_sel),
      .direction_sel(dir), .tx_on(tx_on), .tx_flags(tx_flags)
   );

   r2mf_host r2mf_host_i (
      .sys_clk(sys_clk), .wr_n(wr_n), .rd_n(rd_n), .dout(hd_in), .din(hd_out),
      .oe(oe), .full_n(full_n), .empty(empty)
   );

   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   // =====================================
   // Helpers
   task automatic tally_and_finish();
      $display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR t=%0t got %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic wr(input logic [7:0] b);
      logic ok;
      r2mf_host_i.write_byte(b, ok);
      check({7'h00, ok}, 8'h01);
      tick(2);
   endtask

   task automatic rd(input logic [7:0] exp);
      logic [7:0] b;
      logic       ok;
      r2mf_host_i.read_byte(b, ok);
      check({7'h00, ok}, 8'h01);
      check(b, exp);
   endtask

   task automatic det(input int ch, input logic on, input logic [5:0] f);
      tick(1);
      det_on[ch] = on;
      det_flags[ch*6+:6] = f;
      tick(4);
   endtask

   task automatic no_report();
      tick(10);
      check({7'h00, full_n}, 8'h01);
   endtask

   function automatic logic [7:0] txf(input int ch);
      return {2'b00, tx_flags[ch*6+:6]};
   endfunction

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 8000) begin
         miscompares++;
         tally_and_finish();
      end
   end

   // =====================================
   // Scenarios
   initial begin
      reset_n = 1'b0;
      det_on = 2'b00;
      det_flags = 12'h000;
      miscompares = 0;
      cmp_count = 0;
      cycles = 0;
      tick(10);
      reset_n = 1'b1;
      check({clk_src, coding, ch_on, eot, auto_sel}, 8'h8c);
      check({4'h0, dir, tx_on}, 8'h0c);
      rd(8'h00);
      wr(8'h0b);
      wr(8'h4e);
      check({clk_src, coding, ch_on, eot, auto_sel}, 8'h3b);
      check({6'h00, dir}, 8'h01);
      // Forward channel one, automatic
      wr(8'h83);
      check(txf(0), 8'h03);
      check({6'h00, tx_on}, 8'h01);
      det(0, 1'b1, 6'h05);
      check(txf(0), 8'h00);
      check({6'h00, tx_on}, 8'h00);
      rd(8'h05);
      wr(8'h86);
      check(txf(0), 8'h00);
      det(0, 1'b0, 6'h00);
      check(txf(0), 8'h06);
      no_report();
      // Backward channel two, automatic
      wr(8'hc3);
      check(txf(1), 8'h00);
      det(1, 1'b1, 6'h30);
      check(txf(1), 8'h03);
      check({6'h00, tx_on}, 8'h03);
      rd(8'h70);
      wr(8'hc5);
      check(txf(1), 8'h05);
      det(1, 1'b0, 6'h00);
      check(txf(1), 8'h00);
      rd(8'h40);
      // Binary coding, manual channel one
      wr(8'h19);
      check({clk_src, coding, ch_on, eot, auto_sel}, 8'h7a);
      for (int c = 0; c < 16; c++) begin
         wr(8'h80 | 8'(c));
         check(txf(0), {2'b00, pairs[c]});
      end
      wr(8'hb1);
      check(txf(0), 8'h30);
      det(0, 1'b1, 6'h0a);
      check(txf(0), 8'h30);
      rd(8'h05);
      det(0, 1'b0, 6'h00);
      // Disabled channel
      wr(8'h10);
      check({6'h00, ch_on}, 8'h02);
      check(txf(0), 8'h30);
      wr(8'h83);
      check(txf(0), 8'h30);
      det(0, 1'b1, 6'h03);
      no_report();
      det(0, 1'b0, 6'h00);
      tally_and_finish();
   end
endmodule // r2mf_ctrl_tb
